// ### core/ssw_pkg.sv
/*
  Constants shared by the supply supervisor and watchdog: clock rate, delay figures in their own units,
  the cycle counts derived from them, counter widths and reset values of the input synchroniser.
  Assumes a single 200 MHz clock that runs freely from power-up.
*/
// ============================================================
// supervisor constants
// ============================================================
package ssw_pkg;

  // clock rate; 64 bit so that the products below cannot overflow
  localparam longint unsigned CLK_HZ         = 64'd200_000_000;

  // delay figures as published, in their own units
  localparam longint unsigned RESET_PULSE_MS = 64'd300;   // typical release delay after last cause
  localparam longint unsigned RESET_MIN_MS   = 64'd140;   // least reset pulse width
  localparam longint unsigned WD_TIMEOUT_MS  = 64'd2400;  // watchdog timeout, 2.4 s
  localparam longint unsigned KICK_MIN_NS    = 64'd50;    // least kick pulse width

  // cycle counts; least times round up
  localparam longint unsigned RESET_CYC  = (CLK_HZ * RESET_PULSE_MS + 64'd999) / 64'd1000;
  localparam longint unsigned RESET_MIN_CYC = (CLK_HZ * RESET_MIN_MS + 64'd999) / 64'd1000;
  localparam longint unsigned WD_CYC     = (CLK_HZ * WD_TIMEOUT_MS) / 64'd1000;
  localparam longint unsigned KICK_CYC_L = (CLK_HZ * KICK_MIN_NS + 64'd999_999_999) / 64'd1_000_000_000;

  // counter widths
  localparam int CNT_W  = 32;
  localparam int KICK_W = 8;
  localparam logic [KICK_W-1:0] KICK_CYC = KICK_CYC_L[KICK_W-1:0];

  // synchroniser lanes and their values while reset is applied
  localparam int SYNC_W        = 5;
  localparam int LANE_SUPPLY   = 0;
  localparam int LANE_PF_SENSE = 1;
  localparam int LANE_MANUAL_N = 2;
  localparam int LANE_KICK     = 3;
  localparam int LANE_FLOAT    = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h16;  // supply bad, sense ok, manual idle, kick low, floating

  // watchdog states
  typedef enum logic [1:0] {
    SSW_WD_IDLE,
    SSW_WD_COUNT,
    SSW_WD_TIMEOUT
  } ssw_wd_state_t;

endpackage

// ### core/ssw_sync.sv
/*
  Two-flop synchroniser for a group of independent asynchronous levels.
  Assumes each lane is a slow level; lanes are not coherent with one another.
*/
`timescale 1ns/1ps
// ============================================================
// level synchroniser
// ============================================================
module ssw_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // ssw_sync

// ### core/ssw_top.sv
/*
  Supply supervisor and watchdog: system reset generation from supply-good and manual reset,
  power-fail flag forwarding, and a watchdog on the kick input.
  Assumes the comparator results arrive as digital levels from analog blocks, asynchronous to clk_i,
  and that a floating-detector reports when the kick input is left open or three-stated.
*/
`timescale 1ns/1ps

module ssw_top #(
  parameter int unsigned RESET_CYC = int'(ssw_pkg::RESET_CYC),
  parameter int unsigned WD_CYC    = int'(ssw_pkg::WD_CYC)
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic supply_good_i,          // 1 = supply above reset threshold
  input  wire logic power_fail_sense_in_i,  // 1 = sensed voltage above reference
  input  wire logic manual_reset_n_i,
  input  wire logic watchdog_kick_in_i,
  input  wire logic watchdog_kick_float_i,  // 1 = kick input floating
  output logic      system_reset_n_o,
  output logic      power_fail_flag_n_o,
  output logic      watchdog_timeout_n_o
);

  // ============================================================
  // input synchronisation
  // ============================================================
  logic [ssw_pkg::SYNC_W-1:0] raw_w;
  logic [ssw_pkg::SYNC_W-1:0] sync_w;

  // gather the asynchronous levels into lanes
  assign raw_w[ssw_pkg::LANE_SUPPLY]   = supply_good_i;
  assign raw_w[ssw_pkg::LANE_PF_SENSE] = power_fail_sense_in_i;
  assign raw_w[ssw_pkg::LANE_MANUAL_N] = manual_reset_n_i;
  assign raw_w[ssw_pkg::LANE_KICK]     = watchdog_kick_in_i;
  assign raw_w[ssw_pkg::LANE_FLOAT]    = watchdog_kick_float_i;

  ssw_sync #(
    .W       (ssw_pkg::SYNC_W),
    .RST_VAL (ssw_pkg::SYNC_RST)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (raw_w),
    .sync_o    (sync_w)
  );

  logic supply_ok_w;
  logic pf_sense_ok_w;
  logic manual_active_w;
  logic kick_w;
  logic floating_w;
  assign supply_ok_w     = sync_w[ssw_pkg::LANE_SUPPLY];
  assign pf_sense_ok_w   = sync_w[ssw_pkg::LANE_PF_SENSE];
  assign manual_active_w = !sync_w[ssw_pkg::LANE_MANUAL_N];
  assign kick_w          = sync_w[ssw_pkg::LANE_KICK];
  assign floating_w      = sync_w[ssw_pkg::LANE_FLOAT];

  // ============================================================
  // system reset generation
  // ============================================================
  logic                      cause_w;
  logic [ssw_pkg::CNT_W-1:0] rst_cnt_reg;
  logic                      rst_active_reg;
  localparam logic [ssw_pkg::CNT_W-1:0] RST_LAST = ssw_pkg::CNT_W'(RESET_CYC - 1);

  // any cause keeps the delay restarting
  assign cause_w = !supply_ok_w || manual_active_w;

  // one counter serves all causes; because it restarts on every cause, the pulse always
  // lasts the full release delay, which exceeds the 140 ms floor and also debounces switches
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rst_cnt_reg    <= '0;
      rst_active_reg <= 1'b1;
    end else if (cause_w) begin
      rst_cnt_reg    <= '0;
      rst_active_reg <= 1'b1;
    end else if (rst_active_reg) begin
      if (rst_cnt_reg == RST_LAST) begin
        rst_active_reg <= 1'b0;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
    end
  end

  // the output flop follows the active flag; the cause path adds one cycle of latency only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      system_reset_n_o <= 1'b0;
    end else begin
      system_reset_n_o <= !rst_active_reg && !cause_w;
    end
  end

  // ============================================================
  // power-fail flag
  // ============================================================
  // flag follows the comparator
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      power_fail_flag_n_o <= 1'b1;
    end else begin
      power_fail_flag_n_o <= pf_sense_ok_w;
    end
  end

  // ============================================================
  // kick edge filter
  // ============================================================
  // a new level counts only after it has stood for the least pulse width, so glitches
  // shorter than that are not taken as activity
  logic                       kick_level_reg;
  logic [ssw_pkg::KICK_W-1:0] kick_cnt_reg;
  logic                       kick_edge_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      kick_level_reg <= 1'b0;
      kick_cnt_reg   <= '0;
      kick_edge_reg  <= 1'b0;
    end else begin
      kick_edge_reg <= 1'b0;
      if (kick_w == kick_level_reg) begin
        kick_cnt_reg <= '0;
      end else if (kick_cnt_reg == ssw_pkg::KICK_CYC - 1'b1) begin
        kick_level_reg <= kick_w;
        kick_cnt_reg   <= '0;
        kick_edge_reg  <= 1'b1;
      end else begin
        kick_cnt_reg <= kick_cnt_reg + 1'b1;
      end
    end
  end

  // ============================================================
  // watchdog
  // ============================================================
  ssw_pkg::ssw_wd_state_t    wd_state_reg;
  logic [ssw_pkg::CNT_W-1:0] wd_cnt_reg;
  logic                      wd_off_w;
  localparam logic [ssw_pkg::CNT_W-1:0] WD_LAST = ssw_pkg::CNT_W'(WD_CYC - 1);

  assign wd_off_w = floating_w || rst_active_reg || cause_w;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || wd_off_w) begin
      wd_state_reg <= ssw_pkg::SSW_WD_IDLE;
      wd_cnt_reg   <= '0;
    end else begin
      case (wd_state_reg)
        ssw_pkg::SSW_WD_IDLE: begin
          if (kick_edge_reg) begin
            wd_state_reg <= ssw_pkg::SSW_WD_COUNT;
            wd_cnt_reg   <= '0;
          end
        end
        ssw_pkg::SSW_WD_COUNT: begin
          if (kick_edge_reg) begin
            wd_cnt_reg <= '0;
          end else if (wd_cnt_reg == WD_LAST) begin
            wd_state_reg <= ssw_pkg::SSW_WD_TIMEOUT;
          end else begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
          end
        end
        ssw_pkg::SSW_WD_TIMEOUT: begin
          if (kick_edge_reg) begin
            wd_state_reg <= ssw_pkg::SSW_WD_COUNT;
            wd_cnt_reg   <= '0;
          end
        end
        default: begin
          wd_state_reg <= ssw_pkg::SSW_WD_IDLE;
          wd_cnt_reg   <= '0;
        end
      endcase
    end
  end

  // low supply forces the output low without stretching
  // the board may loop this output back into manual reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      watchdog_timeout_n_o <= 1'b0;
    end else begin
      watchdog_timeout_n_o <= supply_ok_w && (wd_state_reg != ssw_pkg::SSW_WD_TIMEOUT);
    end
  end

endmodule // ssw_top

// ### verif/ssw_assertions.sv
/*
  Port checker for ssw_top, bound to every instance.
  Assumes a single clock and the hand-over latencies of the top module.
*/
`timescale 1ns/1ps
// ============================================================
// port checker
// ============================================================
module ssw_assertions #(
  parameter int unsigned RESET_CYC = 200,
  parameter int unsigned WD_CYC    = 500
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic supply_good_i,
  input wire logic power_fail_sense_in_i,
  input wire logic manual_reset_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_kick_float_i,
  input wire logic system_reset_n_o,
  input wire logic power_fail_flag_n_o,
  input wire logic watchdog_timeout_n_o
);
  logic [31:0] quiet_reg;  // cycles since any reset cause at the pins
  logic [31:0] wdq_reg;    // cycles of an enabled watchdog without a kick
  logic        armed_reg;  // a kick edge was seen since enable
  logic        kick_d_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // counters saturate so a long idle spell cannot wrap
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !supply_good_i || !manual_reset_n_i) quiet_reg <= '0;
    else if (quiet_reg != '1) quiet_reg <= quiet_reg + 1;
  end
  // any disabling cause also forgets earlier kicks
  always_ff @(posedge clk_i) begin
    kick_d_reg <= watchdog_kick_in_i;
    if (!reset_n_i || !supply_good_i || watchdog_kick_float_i || !system_reset_n_o) begin
      wdq_reg   <= '0;
      armed_reg <= 1'b0;
    end else if (watchdog_kick_in_i != kick_d_reg) begin
      wdq_reg   <= '0;
      armed_reg <= 1'b1;
    end else if (wdq_reg != '1) wdq_reg <= wdq_reg + 1;
  end
  property p_low; !supply_good_i [*4] |-> !system_reset_n_o && !watchdog_timeout_n_o; endproperty
  a_low: assert property (p_low) else $error("outputs high while supply low");
  property p_min; $rose(system_reset_n_o) |-> quiet_reg >= RESET_CYC; endproperty
  a_min: assert property (p_min) else $error("reset pulse too short");
  property p_rel; quiet_reg == RESET_CYC + 8 |-> system_reset_n_o; endproperty
  a_rel: assert property (p_rel) else $error("reset not released");
  property p_brown; $fell(supply_good_i) |-> ##[2:3] !system_reset_n_o; endproperty
  a_brown: assert property (p_brown) else $error("brownout reset late");
  property p_manual; $fell(manual_reset_n_i) |-> ##[2:3] !system_reset_n_o; endproperty
  a_manual: assert property (p_manual) else $error("manual reset late");
  property p_pf; $past(reset_n_i, 4) |-> power_fail_flag_n_o == $past(power_fail_sense_in_i, 3); endproperty
  a_pf: assert property (p_pf) else $error("power fail flag wrong");
  property p_wd_dis; (!system_reset_n_o && supply_good_i) [*6] |-> watchdog_timeout_n_o; endproperty
  a_wd_dis: assert property (p_wd_dis) else $error("watchdog active in reset");
  property p_float; (watchdog_kick_float_i && supply_good_i) [*6] |-> watchdog_timeout_n_o; endproperty
  a_float: assert property (p_float) else $error("watchdog active while floating");
  property p_alive; wdq_reg >= 16 && wdq_reg <= WD_CYC - 4 |-> watchdog_timeout_n_o; endproperty
  a_alive: assert property (p_alive) else $error("timeout despite kicks");
  property p_tmo; armed_reg && wdq_reg == WD_CYC + 20 |-> !watchdog_timeout_n_o; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missing");
endmodule // ssw_assertions

bind ssw_top ssw_assertions #(.RESET_CYC(RESET_CYC), .WD_CYC(WD_CYC)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_good_i(supply_good_i),
  .power_fail_sense_in_i(power_fail_sense_in_i), .manual_reset_n_i(manual_reset_n_i),
  .watchdog_kick_in_i(watchdog_kick_in_i), .watchdog_kick_float_i(watchdog_kick_float_i),
  .system_reset_n_o(system_reset_n_o), .power_fail_flag_n_o(power_fail_flag_n_o),
  .watchdog_timeout_n_o(watchdog_timeout_n_o));

// ### verif/ssw_host_model.sv
/*
  Host processor model: toggles the kick pin every PER cycles while enabled.
  Assumes the bench gates it; disabling restarts the period.
*/
`timescale 1ns/1ps
// ============================================================
// host kick model
// ============================================================
module ssw_host_model #(
  parameter int PER = 100
) (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      kick_o
);
  int cnt = 0;
  initial kick_o = 1'b0;
  always @(posedge clk_i) begin
    if (en_i && cnt >= PER - 1) begin
      cnt <= 0;
      kick_o <= #1 ~kick_o;
    end else cnt <= en_i ? cnt + 1 : 0;
  end
endmodule // ssw_host_model

// ### verif/tb.sv
/*
  Self-checking bench for ssw_top with shortened delays.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
// ============================================================
// bench top
// ============================================================
module tb;
  localparam int RC = 200;
  localparam int WC = 500;
  logic clk_i = 0, reset_n_i = 0, supply_good_i = 0, power_fail_sense_in_i = 1;
  logic manual_reset_n_i = 1, watchdog_kick_float_i = 0, host_en = 0;
  logic watchdog_kick_in_i, system_reset_n_o, power_fail_flag_n_o, watchdog_timeout_n_o;
  int   bad_count = 0, num_checks = 0, cyc = 0, n;
  always #2.5 clk_i = ~clk_i;
  ssw_top #(.RESET_CYC(RC), .WD_CYC(WC)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .supply_good_i(supply_good_i), .power_fail_sense_in_i(power_fail_sense_in_i),
    .manual_reset_n_i(manual_reset_n_i), .watchdog_kick_in_i(watchdog_kick_in_i),
    .watchdog_kick_float_i(watchdog_kick_float_i), .system_reset_n_o(system_reset_n_o),
    .power_fail_flag_n_o(power_fail_flag_n_o), .watchdog_timeout_n_o(watchdog_timeout_n_o));
  ssw_host_model #(.PER(100)) u_host (.clk_i(clk_i), .en_i(host_en), .kick_o(watchdog_kick_in_i));
  task automatic chk(input string what, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // inputs always change 1 ns after an edge
  task automatic step(input int k); repeat (k) @(posedge clk_i); #1; endtask
  task automatic wait_rel(output int k);
    k = 0;
    while (system_reset_n_o !== 1'b1 && k < RC + 50) begin step(1); k++; end
  endtask
  task automatic t_power;
    step(20); chk("reset", system_reset_n_o, 0);
    chk("timeout_n", watchdog_timeout_n_o, 0);
    supply_good_i = 1; step(5); chk("timeout_n", watchdog_timeout_n_o, 1);
    wait_rel(n); chk("delay", n + 5 > RC && n + 5 <= RC + 8, 1);
    $display("t_power done");
  endtask
  task automatic t_pf;
    power_fail_sense_in_i = 0; step(4); chk("pf", power_fail_flag_n_o, 0);
    power_fail_sense_in_i = 1; step(4); chk("pf", power_fail_flag_n_o, 1);
    $display("t_pf done");
  endtask
  // brownout is tried from a released reset first, then again inside a running pulse
  task automatic t_mr;
    manual_reset_n_i = 0; step(4); chk("reset", system_reset_n_o, 0);
    step(20); manual_reset_n_i = 1; wait_rel(n); chk("manual pulse", n >= RC && n <= RC + 8, 1);
    supply_good_i = 0; step(4); chk("reset", system_reset_n_o, 0);
    chk("timeout_n", watchdog_timeout_n_o, 0);
    supply_good_i = 1; step(50); manual_reset_n_i = 0; step(5); manual_reset_n_i = 1; step(50);
    supply_good_i = 0; step(5); supply_good_i = 1; step(4);
    chk("timeout_n", watchdog_timeout_n_o, 1);
    wait_rel(n); chk("brown pulse", n + 4 >= RC && n + 4 <= RC + 8, 1);
    $display("t_mr done");
  endtask
  task automatic t_wd;
    step(WC + 40); chk("idle", watchdog_timeout_n_o, 1);
    host_en = 1; step(3 * WC); chk("kicked", watchdog_timeout_n_o, 1);
    host_en = 0; step(WC + 40); chk("tmo", watchdog_timeout_n_o, 0);
    step(200); chk("hold", watchdog_timeout_n_o, 0);
    host_en = 1; step(100); host_en = 0; step(20); chk("kick", watchdog_timeout_n_o, 1);
    step(WC + 40); chk("tmo", watchdog_timeout_n_o, 0);
    watchdog_kick_float_i = 1; step(6); chk("float", watchdog_timeout_n_o, 1);
    step(WC + 40); chk("float", watchdog_timeout_n_o, 1);
    watchdog_kick_float_i = 0;
    $display("t_wd done");
  endtask
  // one kick, then silence; the timeout is fed back into manual reset with 1 ns of wire delay
  task automatic t_loop;
    host_en = 1; step(100); host_en = 0;
    repeat (WC + 40) begin step(1); manual_reset_n_i = watchdog_timeout_n_o; end
    chk("loop reset", system_reset_n_o, 0);
    chk("loop timeout_n", watchdog_timeout_n_o, 1);
    wait_rel(n); chk("loop pulse", n + 20 >= RC && n + 20 <= RC + 8, 1);
    $display("t_loop done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    step(10);
    reset_n_i = 1;
    t_power;
    t_pf;
    t_mr;
    t_wd;
    t_loop;
    final_report;
  end
  // hang guard, about twice the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 12000) begin bad_count++; final_report; end
  end
endmodule // tb
